// ===== hw/cwp_cache_end.sv
`timescale 1ns/1ps
// Cache end: write policy, posted-write queue, victim write-back, snoop and flush
// Overview of operation
// R1: Write-through stores reach memory before completion
// R2: Buffered write-through posts stores into queue
// R3: Read hits served while queue drains
// R4: Full queue stalls further stores
// R5: Read miss waits for empty queue
// R6: Memory side keeps shared data fresh
// R7: Write-back store sets dirty; copy clears
// R8: Dirty victim written back before refill
// R9: Victim address rebuilt from tag, index
// R10: Dirty copies written back before foreign access
// R11: Snooped foreign writes invalidate matching lines
// R12: Only snoop hits disturb cache during DMA
// R13: Every store address broadcast to others
// R14: Non-cacheable accesses never allocate lines
// R15: System decode flags non-cacheable regions
// R16: Flush writes dirty lines, then invalidates all
// R17: Transparent DMA through cache, processor held off
// R18: Video, ROM, expansion regions decoded non-cacheable
// R19: Coherency needs no software involvement
// R20: Four ways, 128 sets, 16-byte lines
// R21: Snooper holds address, then strobes it
// R22: Static mode input selects write policy
// R23: Snoop waits for pending writes to land
module cwp_cache_end import cwp_pkg::*; (
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          ce,
  input  wire logic [1:0]    cfg_mode,
  input  wire logic          cfg_snoop_en,
  input  wire logic          cfg_bcast_en,
  input  wire logic          cpu_valid,
  input  wire logic          cpu_we,
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic [DW-1:0] cpu_wdata,
  output logic               cpu_ready,
  output logic [DW-1:0]      cpu_rdata,
  input  wire logic          flush_req,
  output logic               flush_done,
  cwp_link_if.dev            link
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    cwp_dev_state_type               st;
    cwp_dev_state_type               ret;
    logic                            we;
    logic                            dma;
    logic [AW-1:0]                   addr;
    logic [DW-1:0]                   wdat;
    logic [WRD_W-1:0]                cnt;
    logic [WAY_W-1:0]                way;
    logic [IDX_W-1:0]                li;
    logic [WAY_W-1:0]                rr;
    logic [WAYS-1:0][(1<<IDX_W)-1:0] vld;
    logic [WAYS-1:0][(1<<IDX_W)-1:0] drt;
    logic [Q_DEPTH-1:0][AW-1:0]      qa;
    logic [Q_DEPTH-1:0][DW-1:0]      qd;
    logic [Q_W-1:0]                  qwp;
    logic [Q_W-1:0]                  qrp;
    logic [Q_W:0]                    qcnt;
    logic                            qbusy;
    logic                            mreq;
    logic                            mwe;
    logic [AW-1:0]                   maddr;
    logic [DW-1:0]                   mwdat;
    logic                            rdy;
    logic                            dack;
    logic [DW-1:0]                   rdat;
    logic                            spend;
    logic                            swr;
    logic                            sbusy;
    logic [AW-1:0]                   saddr;
    logic                            bv;
    logic [AW-1:0]                   ba;
    logic                            hack;
    logic                            fpend;
    logic                            fdone;
    logic [FL_W-1:0]                 fix;
  } cwp_dev_regs_type;

  cwp_dev_regs_type r;
  cwp_dev_regs_type n;

  logic [TAG_W-1:0] tag_mem [WAYS][1<<IDX_W];
  logic [DW-1:0]    dat_mem [WAYS][1<<IDX_W][1<<WRD_W];

  function automatic logic [TAG_W-1:0] tag_of(input logic [AW-1:0] a);
    return a[AW-1:TAG_LSB];
  endfunction : tag_of

  function automatic logic [IDX_W-1:0] idx_of(input logic [AW-1:0] a);
    return a[TAG_LSB-1:IDX_LSB];
  endfunction : idx_of

  // Full line address from a tag and index
  function automatic logic [AW-1:0] line_addr(input logic [TAG_W-1:0] t, input logic [IDX_W-1:0] i);
    return {t, i, {WRD_W{1'b0}}, 2'b00};
  endfunction : line_addr

  // ------------------------------------------------------------
  // Lookup
  // ------------------------------------------------------------
  logic [AW-1:0]    la;
  logic             hit;
  logic [WAY_W-1:0] hw;
  logic [WAY_W-1:0] vic;
  logic [WAY_W-1:0] sw;
  logic [IDX_W-1:0] si;

  always_comb begin
    la  = (r.st == DS_SNP) ? r.saddr : r.addr;
    hit = 1'b0;
    hw  = '0;
    vic = r.rr;
    for (int w = 0; w < WAYS; w++) begin
      if (r.vld[w][idx_of(la)] && tag_mem[w][idx_of(la)] == tag_of(la)) begin
        hit = 1'b1;
        hw  = WAY_W'(w);
      end
    end
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (!r.vld[w][idx_of(la)]) begin
        vic = WAY_W'(w);
      end
    end
    case (r.st)
      DS_SNP: begin
        sw = hw;
        si = idx_of(la);
      end
      DS_FLUSH: begin
        sw = r.fix[FL_W-1:IDX_W];
        si = r.fix[IDX_W-1:0];
      end
      default: begin
        sw = vic;
        si = idx_of(la);
      end
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic             d_we;
  logic [WAY_W-1:0] d_way;
  logic [IDX_W-1:0] d_idx;
  logic [WRD_W-1:0] d_wrd;
  logic [DW-1:0]    d_val;
  logic             t_we;
  logic             q_push;
  logic             q_pop;
  logic             wb_go;
  logic             done;
  logic [DW-1:0]    done_dat;
  logic             need_fill;

  always_comb begin
    n        = r;
    n.rdy    = 1'b0;
    n.dack   = 1'b0;
    n.fdone  = 1'b0;
    n.bv     = 1'b0;
    d_we     = 1'b0;
    d_way    = hw;
    d_idx    = idx_of(r.addr);
    d_wrd    = r.addr[IDX_LSB-1:2];
    d_val    = r.wdat;
    t_we     = 1'b0;
    q_push   = 1'b0;
    q_pop    = 1'b0;
    wb_go    = 1'b0;
    done     = 1'b0;
    done_dat = '0;
    need_fill = !link.noncache && !hit && (!r.we || cfg_mode == MODE_WB); // [R14]
    case (r.st)
      DS_IDLE: begin
        if (r.spend) begin
          n.st = DS_SNP;
        end else if (r.fpend) begin
          n.st  = DS_FLUSH;
          n.fix = '0;
        end else if (r.hack) begin
          if (!link.dma_hold_req) begin
            n.hack = 1'b0;
          end else if (link.dma_valid && !r.dack) begin // [R17]
            n.we   = link.dma_we;
            n.addr = link.dma_addr;
            n.wdat = link.dma_wdata;
            n.dma  = 1'b1;
            n.st   = DS_DEC;
          end
        end else if (link.dma_hold_req) begin
          n.hack = (r.qcnt == '0) && !r.mreq; // [R17]
        end else if (cpu_valid && !r.rdy) begin
          n.we   = cpu_we;
          n.addr = cpu_addr;
          n.wdat = cpu_wdata;
          n.dma  = 1'b0;
          n.st   = DS_DEC;
        end
      end
      // Decode answer from the system side lands one cycle later
      DS_DEC: n.st = DS_LOOK;
      DS_LOOK: begin
        if (need_fill) begin
          if (r.qcnt == '0) begin // [R5]
            n.rr = r.rr + 1'b1;
            if (r.vld[vic][si] && r.drt[vic][si]) begin // [R8]
              wb_go = 1'b1;
              n.ret = DS_FILL;
            end else begin
              n.way   = vic;
              n.li    = si;
              n.cnt   = '0;
              n.mreq  = 1'b1;
              n.mwe   = 1'b0;
              n.maddr = line_addr(tag_of(r.addr), si);
              n.st    = DS_FILL;
            end
          end
        end else if (!r.we) begin
          if (!link.noncache) begin
            done     = 1'b1; // [R3]
            done_dat = dat_mem[hw][idx_of(r.addr)][r.addr[IDX_LSB-1:2]];
          end else if (r.qcnt == '0) begin // [R5]
            n.mreq  = 1'b1;
            n.mwe   = 1'b0;
            n.maddr = r.addr;
            n.st    = DS_MRD;
          end
        end else if (cfg_mode == MODE_BWT) begin
          if (r.qcnt != Q_FULL) begin // [R4]
            q_push = 1'b1; // [R2]
            d_we   = hit && !link.noncache;
            done   = 1'b1;
          end
        end else if (cfg_mode == MODE_WB && !link.noncache) begin
          d_we = 1'b1;
          n.drt[hw][idx_of(r.addr)] = 1'b1; // [R7]
          done = 1'b1;
        end else begin
          d_we    = hit && !link.noncache; // [R22]
          n.mreq  = 1'b1; // [R1]
          n.mwe   = 1'b1;
          n.maddr = r.addr;
          n.mwdat = r.wdat;
          n.st    = DS_MWR;
        end
      end
      DS_MRD, DS_MWR: begin
        if (link.mem_ack) begin
          n.mreq   = 1'b0;
          done     = 1'b1;
          done_dat = link.mem_rdata;
        end
      end
      DS_WB: begin
        if (link.mem_ack) begin
          n.cnt   = r.cnt + 1'b1;
          n.maddr = r.maddr + WORD_STEP;
          n.mwdat = dat_mem[r.way][r.li][r.cnt + 1'b1];
          if (r.cnt == WRD_LAST) begin
            n.drt[r.way][r.li] = 1'b0; // [R7]
            n.st    = r.ret;
            n.mreq  = (r.ret == DS_FILL);
            n.mwe   = 1'b0;
            n.maddr = line_addr(tag_of(r.addr), r.li);
          end
        end
      end
      DS_FILL: begin
        if (link.mem_ack) begin
          d_we    = 1'b1;
          d_way   = r.way;
          d_idx   = r.li;
          d_wrd   = r.cnt;
          d_val   = link.mem_rdata;
          n.cnt   = r.cnt + 1'b1;
          n.maddr = r.maddr + WORD_STEP;
          if (r.cnt == WRD_LAST) begin
            t_we   = 1'b1;
            n.mreq = 1'b0;
            n.vld[r.way][r.li] = 1'b1;
            n.drt[r.way][r.li] = 1'b0;
            n.st = DS_LOOK;
          end
        end
      end
      DS_SNP: begin
        if (r.qcnt == '0 && !r.mreq) begin // [R23]
          if (hit && r.drt[sw][si]) begin // [R10]
            wb_go = 1'b1;
            n.ret = DS_SNP;
          end else begin
            if (hit && r.swr && cfg_snoop_en) begin
              n.vld[sw][si] = 1'b0; // [R11] [R12]
            end
            n.spend = 1'b0;
            n.sbusy = 1'b0;
            n.st    = DS_IDLE;
          end
        end
      end
      DS_FLUSH: begin
        if (r.qcnt == '0 && !r.mreq) begin
          if (r.vld[sw][si] && r.drt[sw][si]) begin // [R16]
            wb_go = 1'b1;
            n.ret = DS_FLUSH;
          end else begin
            n.vld[sw][si] = 1'b0; // [R16]
            n.fix = r.fix + 1'b1;
            if (r.fix == FL_LAST) begin
              n.fdone = 1'b1;
              n.fpend = 1'b0;
              n.st    = DS_IDLE;
            end
          end
        end
      end
      default: n.st = DS_IDLE;
    endcase

    // Victim address rebuilt from the stored tag
    if (wb_go) begin
      n.way   = sw;
      n.li    = si;
      n.cnt   = '0;
      n.mreq  = 1'b1;
      n.mwe   = 1'b1;
      n.maddr = line_addr(tag_mem[sw][si], si); // [R9]
      n.mwdat = dat_mem[sw][si][0];
      n.st    = DS_WB;
    end
    if (done) begin
      n.st   = DS_IDLE;
      n.rdat = done_dat;
      n.rdy  = !r.dma;
      n.dack = r.dma;
      n.bv   = r.we && cfg_bcast_en; // [R13]
      n.ba   = r.addr;
    end

    // Posted writes drain only while the line engine leaves memory alone
    if (r.qbusy && link.mem_ack) begin
      q_pop   = 1'b1;
      n.qrp   = r.qrp + 1'b1;
      n.qbusy = 1'b0;
      n.mreq  = 1'b0;
    end else if (!r.mreq && r.qcnt != '0 && r.st != DS_WB && r.st != DS_FILL) begin
      n.qbusy = 1'b1; // [R2]
      n.mreq  = 1'b1;
      n.mwe   = 1'b1;
      n.maddr = r.qa[r.qrp];
      n.mwdat = r.qd[r.qrp];
    end
    if (q_push) begin
      n.qa[r.qwp] = r.addr;
      n.qd[r.qwp] = r.wdat;
      n.qwp = r.qwp + 1'b1;
    end
    n.qcnt = r.qcnt + {{Q_W{1'b0}}, q_push} - {{Q_W{1'b0}}, q_pop};

    // Captures after the state machine so a new event beats its clear
    if (link.address_hold_request && !link.external_address_valid_n) begin
      n.spend = 1'b1; // [R19]
      n.sbusy = 1'b1;
      n.saddr = link.snoop_addr;
      n.swr   = link.snoop_write;
    end
    if (flush_req) begin
      n.fpend = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Registers and arrays
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  // Arrays need no reset: valid bits mask stale tags [R20]
  always_ff @(posedge mclk) begin
    if (ce && d_we) begin
      dat_mem[d_way][d_idx][d_wrd] <= d_val;
    end
    if (ce && t_we) begin
      tag_mem[r.way][r.li] <= tag_of(r.addr);
    end
  end

  assign cpu_ready         = r.rdy;
  assign cpu_rdata         = r.rdat;
  assign flush_done        = r.fdone;
  assign link.mem_req      = r.mreq;
  assign link.mem_we       = r.mwe;
  assign link.mem_addr     = r.maddr;
  assign link.mem_wdata    = r.mwdat;
  assign link.look_addr    = r.addr;
  assign link.snoop_busy   = r.sbusy;
  assign link.bcast_valid  = r.bv;
  assign link.bcast_addr   = r.ba;
  assign link.dma_hold_ack = r.hack;
  assign link.dma_ack      = r.dack;
  assign link.dma_rdata    = r.rdat;
endmodule : cwp_cache_end

// ===== hw/cwp_system_end.sv
`timescale 1ns/1ps
// System end: memory, region decode and foreign-master snoop sequencing
module cwp_system_end import cwp_pkg::*; (
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          ce,
  input  wire logic          cfg_transparent,
  input  wire logic          ext_valid,
  input  wire logic          ext_we,
  input  wire logic [AW-1:0] ext_addr,
  input  wire logic [DW-1:0] ext_wdata,
  output logic               ext_ready,
  output logic [DW-1:0]      ext_rdata,
  cwp_link_if.sys            link
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    cwp_sys_state_type st;
    logic              ack;
    logic [DW-1:0]     rdat;
    logic              nc;
    logic              hreq;
    logic              strbn;
    logic [AW-1:0]     saddr;
    logic              swr;
    logic              dreq;
    logic              dval;
    logic              dwe;
    logic [AW-1:0]     daddr;
    logic [DW-1:0]     dwdat;
    logic              xrdy;
    logic [DW-1:0]     xrdat;
  } cwp_sys_regs_type;

  cwp_sys_regs_type r;
  cwp_sys_regs_type n;

  logic [DW-1:0] mem [1<<MEM_AW];

  function automatic logic is_nc(input logic [AW-1:0] a);
    return ((a & NC_MASK0) == NC_BASE0) || ((a & NC_MASK1) == NC_BASE1) || ((a & NC_MASK2) == NC_BASE2);
  endfunction : is_nc

  logic              m_we;
  logic [MEM_AW-1:0] m_addr;
  logic [DW-1:0]     m_dat;

  always_comb begin
    n      = r;
    n.ack  = 1'b0;
    n.xrdy = 1'b0;
    n.nc   = is_nc(link.look_addr); // [R15] [R18]
    m_we   = 1'b0;
    m_addr = link.mem_addr[MEM_AW+1:2];
    m_dat  = link.mem_wdata;
    // Cache traffic is served in every state but one, so a draining queue never deadlocks a snoop
    if (link.mem_req && !r.ack && r.st != YS_ACC) begin
      n.ack  = 1'b1;
      m_we   = link.mem_we;
      n.rdat = mem[m_addr];
    end
    case (r.st)
      YS_IDLE: begin
        if (ext_valid && !r.xrdy) begin
          if (!cfg_transparent) begin
            n.hreq = 1'b1; // [R21]
            n.st    = YS_HOLD;
          end else if (!link.dma_hold_ack) begin
            n.dreq = 1'b1; // [R17]
            n.st   = YS_DHOLD;
          end
        end
      end
      YS_HOLD: begin
        n.strbn = 1'b0; // [R21]
        n.saddr = ext_addr;
        n.swr   = ext_we;
        n.st    = YS_STRB;
      end
      YS_STRB: begin
        n.strbn = 1'b1;
        n.st    = YS_WAIT;
      end
      YS_WAIT: begin
        if (!link.snoop_busy) begin
          n.st = YS_ACC; // [R6]
        end
      end
      YS_ACC: begin
        m_we    = ext_we;
        m_addr  = ext_addr[MEM_AW+1:2];
        m_dat   = ext_wdata;
        n.xrdat = mem[m_addr];
        n.xrdy  = 1'b1;
        n.hreq  = 1'b0;
        n.st    = YS_IDLE;
      end
      YS_DHOLD: begin
        if (link.dma_hold_ack) begin
          n.dval  = 1'b1; // [R17]
          n.dwe   = ext_we;
          n.daddr = ext_addr;
          n.dwdat = ext_wdata;
          n.st   = YS_DACC;
        end
      end
      YS_DACC: begin
        if (link.dma_ack) begin
          n.dval  = 1'b0;
          n.dreq  = 1'b0;
          n.xrdy  = 1'b1;
          n.xrdat = link.dma_rdata;
          n.st    = YS_IDLE;
        end
      end
      default: n.st = YS_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Registers and memory
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r       <= '0;
      r.strbn <= STRB_N_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && m_we) begin
      mem[m_addr] <= m_dat;
    end
  end

  assign ext_ready                     = r.xrdy;
  assign ext_rdata                     = r.xrdat;
  assign link.mem_ack                  = r.ack;
  assign link.mem_rdata                = r.rdat;
  assign link.noncache                 = r.nc;
  assign link.address_hold_request     = r.hreq;
  assign link.external_address_valid_n = r.strbn;
  assign link.snoop_addr               = r.saddr;
  assign link.snoop_write              = r.swr;
  assign link.dma_hold_req             = r.dreq;
  assign link.dma_valid                = r.dval;
  assign link.dma_we                   = r.dwe;
  assign link.dma_addr                 = r.daddr;
  assign link.dma_wdata                = r.dwdat;
endmodule : cwp_system_end

// ===== shared/cwp_link_if.sv
`timescale 1ns/1ps
// Link between the cache end and the system memory end
interface cwp_link_if;
  import cwp_pkg::*;
  logic          mem_req;
  logic          mem_we;
  logic [AW-1:0] mem_addr;
  logic [DW-1:0] mem_wdata;
  logic          mem_ack;
  logic [DW-1:0] mem_rdata;
  logic [AW-1:0] look_addr;
  logic          noncache;
  logic          address_hold_request;
  logic          external_address_valid_n;
  logic [AW-1:0] snoop_addr;
  logic          snoop_write;
  logic          snoop_busy;
  logic          bcast_valid;
  logic [AW-1:0] bcast_addr;
  logic          dma_hold_req;
  logic          dma_hold_ack;
  logic          dma_valid;
  logic          dma_we;
  logic [AW-1:0] dma_addr;
  logic [DW-1:0] dma_wdata;
  logic          dma_ack;
  logic [DW-1:0] dma_rdata;

  modport dev (
    output mem_req, mem_we, mem_addr, mem_wdata, look_addr, snoop_busy, bcast_valid, bcast_addr,
    output dma_hold_ack, dma_ack, dma_rdata,
    input  mem_ack, mem_rdata, noncache, address_hold_request, external_address_valid_n,
    input  snoop_addr, snoop_write, dma_hold_req, dma_valid, dma_we, dma_addr, dma_wdata
  );
  modport sys (
    input  mem_req, mem_we, mem_addr, mem_wdata, look_addr, snoop_busy, bcast_valid, bcast_addr,
    input  dma_hold_ack, dma_ack, dma_rdata,
    output mem_ack, mem_rdata, noncache, address_hold_request, external_address_valid_n,
    output snoop_addr, snoop_write, dma_hold_req, dma_valid, dma_we, dma_addr, dma_wdata
  );
endinterface : cwp_link_if

// ===== shared/cwp_pkg.sv
// Shared constants and types for the cache write policy and coherency block
package cwp_pkg;
  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int AW      = 32;
  localparam int DW      = 32;
  localparam int WAYS    = 4;
  localparam int WAY_W   = 2;
  localparam int IDX_W   = 7;
  localparam int WRD_W   = 2;
  localparam int TAG_W   = AW - IDX_W - WRD_W - 2;
  localparam int IDX_LSB = WRD_W + 2;
  localparam int TAG_LSB = IDX_LSB + IDX_W;
  localparam int FL_W    = WAY_W + IDX_W;
  localparam int Q_DEPTH = 4;
  localparam int Q_W     = 2;
  localparam int MEM_AW  = 10;

  // ------------------------------------------------------------
  // Modes, decode regions and reset values
  // ------------------------------------------------------------
  localparam logic [1:0]       MODE_WT     = 2'h0;
  localparam logic [1:0]       MODE_BWT    = 2'h1;
  localparam logic [1:0]       MODE_WB     = 2'h2;
  localparam logic [Q_W:0]     Q_FULL      = 3'h4;
  localparam logic [WRD_W-1:0] WRD_LAST    = 2'h3;
  localparam logic [FL_W-1:0]  FL_LAST     = 9'h1FF;
  localparam logic [AW-1:0]    WORD_STEP   = 32'h0000_0004;
  localparam logic [AW-1:0]    NC_BASE0    = 32'h000A_0000;
  localparam logic [AW-1:0]    NC_MASK0    = 32'hFFFE_0000;
  localparam logic [AW-1:0]    NC_BASE1    = 32'h000C_0000;
  localparam logic [AW-1:0]    NC_MASK1    = 32'hFFFC_0000;
  localparam logic [AW-1:0]    NC_BASE2    = 32'h8000_0000;
  localparam logic [AW-1:0]    NC_MASK2    = 32'h8000_0000;
  localparam logic             STRB_N_RST  = 1'b1;

  typedef enum logic [3:0] {
    DS_IDLE, DS_DEC, DS_LOOK, DS_MRD, DS_MWR, DS_WB, DS_FILL, DS_SNP, DS_FLUSH
  } cwp_dev_state_type;

  typedef enum logic [2:0] {
    YS_IDLE, YS_HOLD, YS_STRB, YS_WAIT, YS_ACC, YS_DHOLD, YS_DACC
  } cwp_sys_state_type;
endpackage : cwp_pkg

// ===== verification/cwp_link_props.sv
// Concurrent checks on the link between the cache end and the system end
`timescale 1ns/1ps
module cwp_link_props import cwp_pkg::*; (
  input wire logic          mclk,
  input wire logic          arst_n,
  input wire logic          mem_req,
  input wire logic [AW-1:0] mem_addr,
  input wire logic          mem_ack,
  input wire logic          address_hold_request,
  input wire logic          external_address_valid_n,
  input wire logic          snoop_busy,
  input wire logic          bcast_valid,
  input wire logic          dma_hold_ack,
  input wire logic          dma_ack
);
  // ----------
  // Link protocol
  // ----------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_req_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
  property p_ack_time; $rose(mem_req) |-> ##[1:2] mem_ack; endproperty
  a_ack_time: assert property (p_ack_time) else $error("memory ack late");
  property p_ack_pulse; mem_ack |=> !mem_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  // Strobe is only meaningful while the address is held
  property p_strb_hold; !external_address_valid_n |-> address_hold_request; endproperty
  a_strb_hold: assert property (p_strb_hold) else $error("strobe without hold");
  property p_strb_pulse; !external_address_valid_n |=> external_address_valid_n; endproperty
  a_strb_pulse: assert property (p_strb_pulse) else $error("strobe held too long");
  property p_snp_busy; !external_address_valid_n |-> ##[1:2] snoop_busy; endproperty
  a_snp_busy: assert property (p_snp_busy) else $error("snoop not taken");
  property p_bc_pulse; bcast_valid |=> !bcast_valid; endproperty
  a_bc_pulse: assert property (p_bc_pulse) else $error("broadcast held too long");
  property p_dma_ack; dma_ack |-> dma_hold_ack; endproperty
  a_dma_ack: assert property (p_dma_ack) else $error("dma ack outside hold");
endmodule : cwp_link_props

// ===== verification/tb.sv
// Bench joining the cache end and the system end over the link
`timescale 1ns/1ps
module tb;
  import cwp_pkg::*;
  typedef struct packed {
    logic [1:0]    mode;
    logic          ext;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } cwp_row_type;
  logic          mclk = 1'b0;
  logic          arst_n = 1'b0;
  logic [1:0]    cfg_mode = MODE_WT;
  logic          cfg_transparent = 1'b0;
  logic          cpu_valid = 1'b0, cpu_we = 1'b0, ext_valid = 1'b0, ext_we = 1'b0, flush_req = 1'b0;
  logic [AW-1:0] cpu_addr = '0, ext_addr = '0;
  logic [DW-1:0] cpu_wdata = '0, ext_wdata = '0, cpu_rdata, ext_rdata, rd;
  logic          cpu_ready, ext_ready, flush_done;
  int            err_count = 0, num_checks = 0, bcasts = 0, n;
  cwp_row_type   rows [17];
  cwp_link_if    link ();
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (link.bcast_valid === 1'b1) bcasts <= bcasts + 1;
  cwp_cache_end u_cwp_cache_end (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .cfg_mode(cfg_mode), .cfg_snoop_en(1'b1),
    .cfg_bcast_en(1'b1), .cpu_valid(cpu_valid), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .flush_req(flush_req), .flush_done(flush_done), .link(link));
  cwp_system_end u_cwp_system_end (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .cfg_transparent(cfg_transparent),
    .ext_valid(ext_valid), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_ready(ext_ready),
    .ext_rdata(ext_rdata), .link(link));
  cwp_link_props u_cwp_link_props (.mclk(mclk), .arst_n(arst_n), .mem_req(link.mem_req),
    .mem_addr(link.mem_addr), .mem_ack(link.mem_ack), .address_hold_request(link.address_hold_request),
    .external_address_valid_n(link.external_address_valid_n), .snoop_busy(link.snoop_busy),
    .bcast_valid(link.bcast_valid), .dma_hold_ack(link.dma_hold_ack), .dma_ack(link.dma_ack));
  // ----------
  // Tasks
  // ----------
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bail();
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask : bail
  // Valid stays up between rows so requests can run back to back
  task automatic xfer(input cwp_row_type r, output logic [DW-1:0] q);
    int k;
    k = 0;
    cfg_mode = r.mode;
    {cpu_valid, ext_valid} = {!r.ext, r.ext};
    {cpu_we, cpu_addr, cpu_wdata} = {r.we, r.addr, r.data};
    {ext_we, ext_addr, ext_wdata} = {r.we, r.addr, r.data};
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while ((r.ext ? ext_ready : cpu_ready) !== 1'b1 && k < 4000);
    if (k >= 4000) bail();
    q = r.ext ? ext_rdata : cpu_rdata;
    @(posedge mclk);
    #1;
  endtask : xfer
  // ----------
  // Sequence
  // ----------
  initial begin
    rows = '{'{MODE_WT, 1'b0, 1'b1, 32'h100, 32'h11}, '{MODE_WT, 1'b1, 1'b0, 32'h100, 32'h11},
      '{MODE_WT, 1'b0, 1'b0, 32'h100, 32'h11}, '{MODE_WT, 1'b1, 1'b1, 32'h100, 32'h22},
      '{MODE_WT, 1'b0, 1'b0, 32'h100, 32'h22}, '{MODE_BWT, 1'b0, 1'b1, 32'h200, 32'hA0},
      '{MODE_BWT, 1'b0, 1'b1, 32'h204, 32'hA1}, '{MODE_BWT, 1'b0, 1'b1, 32'h208, 32'hA2},
      '{MODE_BWT, 1'b0, 1'b1, 32'h20C, 32'hA3}, '{MODE_BWT, 1'b0, 1'b1, 32'h210, 32'hA4},
      '{MODE_BWT, 1'b0, 1'b0, 32'h200, 32'hA0}, '{MODE_BWT, 1'b1, 1'b0, 32'h210, 32'hA4},
      '{MODE_WB, 1'b0, 1'b1, 32'h5A4, 32'hD00D}, '{MODE_WB, 1'b0, 1'b0, 32'h5A4, 32'hD00D},
      '{MODE_WB, 1'b1, 1'b0, 32'h5A4, 32'hD00D}, '{MODE_WB, 1'b0, 1'b1, 32'hA0010, 32'h33},
      '{MODE_WB, 1'b1, 1'b0, 32'h10, 32'h33}};
    repeat (20) @(posedge mclk);
    #1;
    chk({29'h0, cpu_ready, link.mem_req, link.external_address_valid_n}, 32'h1);
    arst_n = 1'b1;
    foreach (rows[i]) begin
      xfer(rows[i], rd);
      if (!rows[i].we) chk(rd, rows[i].data);
    end
    xfer(cwp_row_type'{MODE_WB, 1'b0, 1'b1, 32'h300, 32'h55}, rd);
    {cpu_valid, ext_valid, flush_req} = 3'h1;
    @(posedge mclk);
    #1;
    flush_req = 1'b0;
    for (n = 0; n < 8000 && flush_done !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    if (n >= 8000) bail();
    chk(32'(bcasts), 32'h9);
    // Dirty copy only survives the flush if it was written out first
    xfer(cwp_row_type'{MODE_WB, 1'b1, 1'b0, 32'h300, 32'h55}, rd);
    chk(rd, 32'h55);
    cfg_transparent = 1'b1;
    xfer(cwp_row_type'{MODE_WB, 1'b1, 1'b1, 32'h400, 32'h44}, rd);
    xfer(cwp_row_type'{MODE_WB, 1'b0, 1'b0, 32'h400, 32'h44}, rd);
    chk(rd, 32'h44);
    cpu_valid = 1'b0;
    test_done();
  end
endmodule : tb
